// ===== logic/led_seq.sv
/*
  Indicator sequencer: fault classing, blink codes, boot lamp test,
  lockout, serial activity lamps and an APB register slave.
  Assumes one 250 MHz clock; run, clear, overcurrent and over-temperature pins come in asynchronous and are synchronised.
*/
`timescale 1ns/100ps
`default_nettype none
`include "led_seq_defs.svh"
module led_seq #(
  parameter logic [17:0] TICK_CYC = 18'(`TICK_NS / `CLK_NS)
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_n_in,
  input  wire led_seq_pkg::apb_req_t  apb_in,
  output var  led_seq_pkg::apb_rsp_t  apb_out,
  input  wire logic                   hardware_run_input_n_in,
  input  wire logic                   fault_clear_input_n_in,
  input  wire logic                   overcurrent_in,
  input  wire logic                   overtemp_in,
  input  wire logic                   sensor_valid_in,
  input  wire logic [11:0]            sensor_mv_in,
  input  wire logic signed [15:0]     temp_in,
  input  wire logic signed [15:0]     setpoint_in,
  input  wire logic                   rx_pulse_in,
  input  wire logic                   tx_pulse_in,
  input  wire logic                   session_in,
  input  wire logic                   pos_cmd_in,
  input  wire logic                   neg_cmd_in,
  output var  led_seq_pkg::led_t      led_out,
  output      logic                   peltier_positive_output_out,
  output      logic                   peltier_negative_output_out,
  output      logic [12:0]            sensor_current_ua_out
);
  import led_seq_pkg::*;

  state_t             q;
  state_t             d;
  logic               tick;
  logic               half_end;
  logic               run;
  logic               clr;
  logic               oc;
  logic               ot;
  logic               sens_bad;
  logic               fen;
  logic signed [16:0] diff;
  logic               in_band;
  logic               cold;
  logic               acc;
  logic               mapped;
  logic [2:0]         err_n;
  logic [2:0]         stat_n;
  logic [1:0]         pulse;

  // Burst of n flashes over an eight-slot frame; slots past n stay dark
  function automatic logic flash(input logic [3:0] ph, input logic [2:0] n);
    flash = (ph[3:1] < n) && !ph[0];
  endfunction : flash

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    // First stage read only by the second
    d.s1 = {overtemp_in, overcurrent_in, fault_clear_input_n_in, hardware_run_input_n_in};
    d.s2 = q.s1;
    run = !q.s2[0];
    clr = !q.s2[1];
    oc = q.s2[2];
    ot = q.s2[3];

    tick = (q.tick_cnt == TICK_CYC - 18'h00001);
    half_end = tick && (q.ms_cnt == `HALF_LAST);
    d.tick_cnt = tick ? 18'h00000 : q.tick_cnt + 18'h00001;
    if (tick)
    begin
      d.ms_cnt = half_end ? 8'h00 : q.ms_cnt + 8'h01;
    end
    if (half_end)
    begin
      d.phase = q.phase + 4'h1;
    end

    // Faults latch; a new cause wins over a clear in the same cycle
    sens_bad = sensor_valid_in && ((sensor_mv_in < `SENS_MIN_MV)
               || (sensor_mv_in > `SENS_MAX_MV));
    d.sens_f = sens_bad || (q.sens_f && !clr);
    d.oc_f = oc || (q.oc_f && !clr);
    d.ot_f = ot || (q.ot_f && !clr);

    fen = run && (!q.sw_mode || q.start) && (q.mode == RUN);
    // Drive gated by the hardware comparator, no software in the path
    d.pel_pos = pos_cmd_in && fen && !oc && !q.oc_f && !q.ot_f && !q.sens_f;
    d.pel_neg = neg_cmd_in && fen && !oc && !q.oc_f && !q.ot_f && !q.sens_f;

    diff = {temp_in[15], temp_in} - {setpoint_in[15], setpoint_in};
    in_band = (diff >= -`BAND_DC) && (diff <= `BAND_DC);
    cold = diff < -`BAND_DC;

    // Lowest flash count wins when faults overlap
    err_n = q.sens_f ? 3'h1 : q.oc_f ? 3'h2 : q.ot_f ? 3'h3 : 3'h0;
    stat_n = cold ? 3'h1 : 3'h2;

    // APB slave: zero wait states, read data captured in setup
    acc = apb_in.psel && apb_in.penable;
    mapped = (apb_in.paddr == `OFS_CTRL) || (apb_in.paddr == `OFS_CURRENT)
             || (apb_in.paddr == `OFS_STATUS) || (apb_in.paddr == `OFS_SENSOR);
    if (apb_in.psel && !apb_in.penable)
    begin
      case (apb_in.paddr)
        `OFS_CTRL:    d.prdata = {29'h0, q.mode == LOCK, q.start, q.sw_mode};
        `OFS_CURRENT: d.prdata = {19'h0, q.cur};
        `OFS_STATUS:  d.prdata = {23'h0, q.mode == LOCK, q.mode != RUN && q.mode != LOCK,
                                  cold, in_band, fen, q.ot_f, q.oc_f, q.sens_f};
        `OFS_SENSOR:  d.prdata = {20'h0, sensor_mv_in};
        default:      d.prdata = 32'h0;
      endcase
    end
    if (acc && apb_in.pwrite && apb_in.paddr == `OFS_CTRL)
    begin
      d.sw_mode = apb_in.pwdata[`CTRL_SWMODE];
      d.start = apb_in.pwdata[`CTRL_START];
      if (apb_in.pwdata[`CTRL_LOCK])
      begin
        d.mode = LOCK;
      end
    end
    if (acc && apb_in.pwrite && apb_in.paddr == `OFS_CURRENT)
    begin
      d.cur = apb_in.pwdata[12:0];
    end

    // Mode sequencing and operating lamps
    case (q.mode)
      BOOT_RED, BOOT_YEL, BOOT_GRN:
      begin
        d.led.err = (q.mode == BOOT_RED) && !q.phase[3];
        d.led.stat = (q.mode == BOOT_YEL) && !q.phase[3];
        d.led.cpu = (q.mode == BOOT_GRN) && !q.phase[3];
        if (half_end && q.phase == 4'hf && d.mode != LOCK)
        begin
          d.mode = (q.mode == BOOT_RED) ? BOOT_YEL : (q.mode == BOOT_YEL) ? BOOT_GRN : RUN;
        end
      end
      RUN:
      begin
        d.led.err = (err_n != 3'h0) && flash(q.phase, err_n);
        if (!fen)
        begin
          d.led.stat = 1'b0;
        end
        else if (in_band)
        begin
          d.led.stat = 1'b1;
        end
        else
        begin
          d.led.stat = flash(q.phase, stat_n);
        end
        d.led.cpu = q.phase[2];
      end
      LOCK:
      begin
        // Nothing leaves this state; only the power-on reset does
        d.mode = LOCK;
        d.led.err = q.phase[1];
        d.led.stat = q.phase[1];
        d.led.cpu = q.phase[1];
      end
      default:
      begin
        d.mode = LOCK;
      end
    endcase

    // Serial lamps: stretched flash per event; a running flash is not retriggered
    pulse = {tx_pulse_in, rx_pulse_in};
    for (int i = 0; i < 2; i++)
    begin
      if (q.act[i] == 6'h00 && pulse[i])
      begin
        d.act[i] = `ACT_FULL;
      end
      else if (tick && q.act[i] != 6'h00)
      begin
        d.act[i] = q.act[i] - 6'h01;
      end
    end
    d.led.rx = session_in ? q.phase[0] : (q.act[0] > `ACT_HALF);
    d.led.tx = session_in ? q.phase[0] : (q.act[1] > `ACT_HALF);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q <= '0;
      q.s1 <= 4'h3;
      q.s2 <= 4'h3;
      q.mode <= BOOT_RED;
      q.cur <= `CURRENT_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign apb_out = '{pready: 1'b1, pslverr: acc && !mapped, prdata: q.prdata};
  assign led_out = q.led;
  assign peltier_positive_output_out = q.pel_pos;
  assign peltier_negative_output_out = q.pel_neg;
  assign sensor_current_ua_out = q.cur;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sens_short_a: assert property (sensor_valid_in && sensor_mv_in < `SENS_MIN_MV |=> q.sens_f)
    else $error("short sensor not flagged");
  sens_open_a: assert property (sensor_valid_in && sensor_mv_in > `SENS_MAX_MV |=> q.sens_f)
    else $error("open sensor not flagged");
  err_dark_a: assert property (q.mode == RUN && !q.sens_f && !q.oc_f && !q.ot_f |=> !q.led.err)
    else $error("error lamp lit without fault");
  oc_code_a: assert property (q.mode == RUN && !q.sens_f && q.oc_f && q.phase == 4'h2 |=> q.led.err)
    else $error("overcurrent second flash missing");
  ot_code_a: assert property (q.mode == RUN && !q.sens_f && !q.oc_f && q.ot_f
                              && q.phase == 4'h4 |=> q.led.err)
    else $error("over-temperature third flash missing");
  stat_off_a: assert property (q.mode == RUN && !fen |=> !q.led.stat)
    else $error("status lamp lit while disabled");
  stat_band_a: assert property (fen && in_band |=> q.led.stat)
    else $error("status lamp dark in band");
  lock_blink_a: assert property (q.mode == LOCK |=> q.led.err == q.led.stat && q.led.stat == q.led.cpu)
    else $error("lockout lamps out of phase");
  lock_hold_a: assert property (q.mode == LOCK |=> q.mode == LOCK [*4])
    else $error("lockout left");
  oc_cut_a: assert property (oc |=> !q.pel_pos && !q.pel_neg)
    else $error("drive not cut on overcurrent");
  boot_order_a: assert property (q.mode == BOOT_RED |=> q.mode inside {BOOT_RED, BOOT_YEL, LOCK})
    else $error("boot order broken");

  // ----------------------------------------------------------------
  // Checks: latches, enable and drive
  // ----------------------------------------------------------------
  oc_latch_a: assert property (oc |=> q.oc_f)
    else $error("overcurrent not latched");
  ot_latch_a: assert property (ot |=> q.ot_f)
    else $error("over-temperature not latched");
  clr_sens_a: assert property (clr && !sens_bad |=> !q.sens_f)
    else $error("sensor fault not cleared");
  sens_hold_a: assert property (q.sens_f && !clr |=> q.sens_f)
    else $error("sensor fault lost without clear");
  oc_hold_a: assert property (q.oc_f && !clr |=> q.oc_f)
    else $error("overcurrent fault lost without clear");
  hardware_run_input_a: assert property (q.mode == RUN && run && !q.sw_mode |-> fen)
    else $error("hardware mode not enabled");
  sw_gate_a: assert property (q.sw_mode && !q.start |-> !fen)
    else $error("software mode enabled without start");
  fault_cut_a: assert property (q.sens_f || q.oc_f || q.ot_f |=> !q.pel_pos && !q.pel_neg)
    else $error("drive on with latched fault");
  lock_enter_a: assert property (acc && apb_in.pwrite && apb_in.paddr == `OFS_CTRL
                                 && apb_in.pwdata[`CTRL_LOCK] |=> q.mode == LOCK)
    else $error("lockout not entered");

  // ----------------------------------------------------------------
  // Checks: lamp patterns
  // ----------------------------------------------------------------
  err_sens_a: assert property (q.mode == RUN && q.sens_f && q.phase == 4'h2 |=> !q.led.err)
    else $error("sensor fault shows more than one flash");
  cold_flash_a: assert property (fen && cold && q.phase == 4'h2 |=> !q.led.stat)
    else $error("too cold shows a second flash");
  hot_flash_a: assert property (fen && !cold && !in_band && q.phase == 4'h2 |=> q.led.stat)
    else $error("too hot second flash missing");
  heart_beat_a: assert property (q.mode == RUN && q.phase[2] |=> q.led.cpu)
    else $error("heartbeat lamp dark");
  boot_green_a: assert property (q.mode == BOOT_GRN && !q.phase[3] |=> q.led.cpu && !q.led.err && !q.led.stat)
    else $error("green lamp test wrong");
  rx_load_a: assert property (q.act[0] == 6'h00 && rx_pulse_in |=> q.act[0] == `ACT_FULL)
    else $error("receive flash not started");
  tx_lamp_a: assert property (!session_in && q.act[1] > `ACT_HALF |=> q.led.tx)
    else $error("transmit lamp dark during flash");
  session_lamps_a: assert property (session_in |=> q.led.rx == q.led.tx)
    else $error("session lamps out of step");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  boot_done_c: cover property (q.mode == BOOT_GRN ##1 q.mode == RUN);
  drive_c: cover property (q.pel_pos && !q.pel_neg);
  lock_c: cover property (q.mode == RUN ##1 q.mode == LOCK);
  sens_c: cover property (q.mode == RUN && q.sens_f && q.led.err);
  session_c: cover property (session_in && q.led.rx && q.led.tx);
endmodule : led_seq
`default_nettype wire

// ===== pkg/led_seq_defs.svh
/*
  Constants of the indicator sequencer: register offsets, field positions,
  reset values and timing figures. Assumes a 250 MHz system clock.
*/
// Function
// - Sensor voltage under 0,08 V means shorted sensor; set sensor fault.
// - Sensor voltage over 2,30 V means broken wire; set same fault.
// - Error lamp dark without fault; one flash on sensor fault.
// - Error lamp gives two flashes on output overcurrent fault.
// - Error lamp gives three flashes on power stage over-temperature.
// - Status lamp off while combined run enable is inactive.
// - Status lamp steady on when enabled and within one degree.
// - Status lamp single flash when enabled and too cold.
// - Status lamp double flash when enabled and too hot.
// - Heartbeat lamp toggles periodically once boot has finished.
// - Boot lamp test lights red, yellow, green in turn, then runs.
// - Lockout blinks all three state lamps together, in phase.
// - Lockout is left only by power cycle; nothing else exits.
// - Receive and transmit lamps flash with serial traffic.
// - Active host session flashes both serial lamps periodically.
// - Overcurrent from hardware blocks the output drive directly.
// - Sensor current setting resets to 1 mA; changed by configuration.
// - Fault clear input clears latched errors, no processor reset.
// - Hardware mode: pin alone enables; software mode needs start too.
`ifndef LED_SEQ_DEFS_SVH
`define LED_SEQ_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define OFS_CTRL     12'h000
`define OFS_CURRENT  12'h004
`define OFS_STATUS   12'h008
`define OFS_SENSOR   12'h00c
`define CTRL_SWMODE  0
`define CTRL_START   1
`define CTRL_LOCK    2
`define CURRENT_RST  13'h03e8
// ----------------------------------------------------------------
// Analog limits, millivolts and tenths of a degree
// ----------------------------------------------------------------
`define SENS_MIN_MV  12'h050
`define SENS_MAX_MV  12'h8fc
`define BAND_DC      17'sh0000a
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_NS       4
`define TICK_NS      1000000
`define HALF_LAST    8'h63
`define ACT_FULL     6'h3c
`define ACT_HALF     6'h1e

`endif

// ===== pkg/led_seq_pkg.sv
/*
  Types of the indicator sequencer: modes, bus carriers, lamp group and
  the module state. Assumes the constants header is compiled alongside.
*/
`default_nettype none
package led_seq_pkg;
  typedef enum logic [2:0] {BOOT_RED, BOOT_YEL, BOOT_GRN, RUN, LOCK} mode_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  typedef struct packed {
    logic err;
    logic stat;
    logic cpu;
    logic rx;
    logic tx;
  } led_t;
  typedef struct packed {
    logic [3:0]      s1;
    logic [3:0]      s2;
    logic [17:0]     tick_cnt;
    logic [7:0]      ms_cnt;
    logic [3:0]      phase;
    mode_t           mode;
    logic            sw_mode;
    logic            start;
    logic [12:0]     cur;
    logic [31:0]     prdata;
    logic            sens_f;
    logic            oc_f;
    logic            ot_f;
    logic [1:0][5:0] act;
    led_t            led;
    logic            pel_pos;
    logic            pel_neg;
  } state_t;
endpackage : led_seq_pkg
`default_nettype wire

// ===== verif/led_viewer.sv
/*
  Operator view of the five lamps: counts rising edges of each lamp.
  Assumes the bench clears it at the start of each viewing window.
*/
`timescale 1ns/100ps
`default_nettype none
module led_viewer
  import led_seq_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       clr_in,
  input  wire led_t       led_in,
  output logic [4:0][7:0] edges_out
);
  led_t prev_q;
  // Index 0 err, 1 stat, 2 cpu, 3 rx, 4 tx
  always_ff @(posedge clk_in)
  begin
    prev_q <= led_in;
    for (int i = 0; i < 5; i++)
      if (clr_in)
        edges_out[i] <= 8'h00;
      else if (led_in[4-i] && !prev_q[4-i])
        edges_out[i] <= edges_out[i] + 8'h01;
  end
endmodule : led_viewer
`default_nettype wire

// ===== verif/testbench.sv
/*
  Self-checking bench of the indicator sequencer.
  Assumes TICK_CYC of 4, so one blink frame lasts 6400 clocks.
*/
`timescale 1ns/100ps
`default_nettype none
`include "led_seq_defs.svh"
module testbench;
  import led_seq_pkg::*;
  localparam int FRAME = 6400;
  logic               sys_clk_in, rst_n_in, run_n, clr_n, oc, ot, vld, rx, tx, sess, pcmd, ncmd, vclr, e;
  logic [11:0]        mv;
  logic signed [15:0] temp, setp;
  apb_req_t           req;
  apb_rsp_t           rsp;
  led_t               led;
  logic               pos_o, neg_o;
  logic [12:0]        cur_o, w;
  logic [4:0][7:0]    ed;
  logic [31:0]        r;
  int                 miscompares = 0, comparisons = 0, d;

  led_seq #(.TICK_CYC(18'h00004)) dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .apb_in(req),
    .apb_out(rsp), .hardware_run_input_n_in(run_n), .fault_clear_input_n_in(clr_n), .overcurrent_in(oc),
    .overtemp_in(ot), .sensor_valid_in(vld), .sensor_mv_in(mv), .temp_in(temp), .setpoint_in(setp),
    .rx_pulse_in(rx), .tx_pulse_in(tx), .session_in(sess), .pos_cmd_in(pcmd), .neg_cmd_in(ncmd),
    .led_out(led), .peltier_positive_output_out(pos_o), .peltier_negative_output_out(neg_o),
    .sensor_current_ua_out(cur_o));
  led_viewer view (.clk_in(sys_clk_in), .clr_in(vclr), .led_in(led), .edges_out(ed));

  function automatic logic bad_mv(input logic [11:0] v);
    return v < 12'h050 || v > 12'h8fc;
  endfunction : bad_mv
  function automatic logic [1:0] zone(input int x);
    return {x < -10, x >= -10 && x <= 10};
  endfunction : zone

  task automatic check(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : check
  task automatic conclude();
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : cyc
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dt);
    int n;
    @(posedge sys_clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: dt};
    @(posedge sys_clk_in);
    req.penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge sys_clk_in);
      if (rsp.pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      miscompares++;
      conclude();
    end
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic feed(input logic [11:0] v);
    @(posedge sys_clk_in);
    mv <= v;
    vld <= 1'b1;
    @(posedge sys_clk_in);
    vld <= 1'b0;
    cyc(3);
  endtask : feed
  task automatic clear();
    clr_n <= 1'b0;
    cyc(8);
    clr_n <= 1'b1;
    cyc(5);
  endtask : clear
  task automatic sense(input logic [11:0] v);
    feed(v);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("sensor fault", bad_mv(v), r[0]);
    apb(1'b0, `OFS_SENSOR, 32'h0);
    check("sensor reg", v, r[11:0]);
    feed(12'h3e8);
    clear();
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("fault cleared", 1'b0, r[0]);
  endtask : sense
  // Counts exactly one frame of edges, so phase alignment does not matter
  task automatic watch();
    @(posedge sys_clk_in);
    vclr <= 1'b1;
    @(posedge sys_clk_in);
    vclr <= 1'b0;
    cyc(FRAME);
    @(posedge sys_clk_in);
  endtask : watch

  initial
  begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    #360000;
    miscompares++;
    conclude();
  end

  initial
  begin
    void'($urandom(81715));
    {rst_n_in, vld, rx, tx, sess, pcmd, ncmd, oc, ot, vclr} = '0;
    {run_n, clr_n} = 2'b11;
    mv = 12'h3e8;
    temp = 16'sh00fa;
    setp = 16'sh00fa;
    req = '0;
    cyc(20);
    check("current", 32'h3e8, cur_o);
    rst_n_in <= 1'b1;
    cyc(100);
    #1 check("boot red", 5'b10000, led);
    cyc(FRAME);
    #1 check("boot yellow", 5'b01000, led);
    cyc(FRAME);
    #1 check("boot green", 5'b00100, led);
    cyc(FRAME + 100);
    repeat (3)
    begin
      w = 13'($urandom_range(8191, 0));
      apb(1'b1, `OFS_CURRENT, {19'h0, w});
      apb(1'b0, `OFS_CURRENT, 32'h0);
      check("current reg", w, r[12:0]);
      check("current out", w, cur_o);
    end
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", 1'b1, e);
    sense(12'h04f);
    sense(12'h050);
    sense(12'h8fc);
    sense(12'h8fd);
    repeat (4) sense(12'($urandom_range(4095, 0)));
    feed(12'h010);
    watch();
    check("err one", 1, ed[0]);
    check("stat off", 0, {ed[1], led.stat});
    check("heartbeat", 2, ed[2]);
    oc <= 1'b1;
    watch();
    check("err lowest", 1, ed[0]);
    feed(12'h3e8);
    clear();
    watch();
    check("err two", 2, ed[0]);
    ot <= 1'b1;
    oc <= 1'b0;
    clear();
    watch();
    check("err three", 3, ed[0]);
    ot <= 1'b0;
    clear();
    run_n <= 1'b0;
    pcmd <= 1'b1;
    sess <= 1'b1;
    cyc(4);
    watch();
    check("err dark", 0, {ed[0], led.err});
    check("stat steady", 1, {ed[1], led.stat});
    check("session", {8'h08, 8'h08}, {ed[4], ed[3]});
    check("drive", 2'b10, {pos_o, neg_o});
    sess <= 1'b0;
    temp <= 16'sh00ef;
    watch();
    check("too cold", 1, ed[1]);
    temp <= 16'sh0105;
    watch();
    check("too hot", 2, ed[1]);
    repeat (6)
    begin
      d = int'($urandom_range(60, 0)) - 30;
      temp <= setp + 16'(d);
      cyc(4);
      apb(1'b0, `OFS_STATUS, 32'h0);
      check("zone", zone(d), r[5:4]);
    end
    oc <= 1'b1;
    cyc(6);
    check("short cut", 0, pos_o);
    oc <= 1'b0;
    clear();
    apb(1'b1, `OFS_CTRL, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("sw no start", 0, r[3]);
    apb(1'b1, `OFS_CTRL, 32'h3);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("sw start", 1, r[3]);
    run_n <= 1'b1;
    cyc(10);
    check("disabled", 0, led.stat);
    rx <= 1'b1;
    cyc(1);
    rx <= 1'b0;
    tx <= 1'b1;
    cyc(1);
    tx <= 1'b0;
    cyc(20);
    check("activity", 2'b11, {led.rx, led.tx});
    apb(1'b1, `OFS_CTRL, 32'h4);
    watch();
    check("lock blink", {8'h04, 8'h04, 8'h04}, {ed[2], ed[1], ed[0]});
    check("in phase", {led.err, led.err}, {led.stat, led.cpu});
    run_n <= 1'b0;
    clear();
    apb(1'b1, `OFS_CTRL, 32'h0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("locked", 1, r[7]);
    conclude();
  end
endmodule : testbench
`default_nettype wire
